// >>> rtl/dual_timer_consts.svh
`ifndef DUAL_TIMER_CONSTS_SVH
`define DUAL_TIMER_CONSTS_SVH

// ---------------------------------------------------------------
// register indices (byte address = 4 * index)
// ---------------------------------------------------------------
`define IDX_IRQ_CTRL     10'h088
`define IDX_TIMER_MODE   10'h089
`define IDX_T0_LOW       10'h08a
`define IDX_T1_LOW       10'h08b
`define IDX_T0_HIGH      10'h08c
`define IDX_T1_HIGH      10'h08d
`define IDX_EVT_STATUS   10'h090
`define IDX_EVT_MASK     10'h091

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define CTRL_TYPE_BIT    0
`define CTRL_FLAG_BIT    1
`define CTRL_RUN0_BIT    4
`define CTRL_RUN1_BIT    6
`define EVT_IRQ0_BIT     0
`define EVT_T0_BIT       1
`define EVT_T1_BIT       2
`define RST_BYTE         8'h00
`define RST_EVT          3'h0
`define INT_CLK_DIV      12

`endif

// >>> rtl/dual_timer_pkg.sv
package dual_timer_pkg;
  typedef enum logic [1:0] {
    MODE_13BIT   = 2'b00,
    MODE_16BIT   = 2'b01,
    MODE_RELOAD8 = 2'b10,
    MODE_RSVD    = 2'b11
  } timer_mode_t;
endpackage

// >>> rtl/dual_timer_counter.sv
// Functional notes
// - ext irq 0 flag sets on the selected edge or level condition
// - edge mode: flag clears on vector ack; level mode: flag follows the inverse of the pin
// - type bit selects falling edge or low level for ext irq 0
// - mode register: upper nibble timer 1, lower nibble timer 0
// - gate set: count only while ext irq pin high and run bit set
// - gate clear: count whenever run bit set
// - select clear: count internal clock ticks
// - select set: count falling edges of the count-input pin
// - mode 00 13-bit, 01 16-bit, 10 8-bit reload, 11 reserved
// - mode 1: high and low bytes form one 16-bit up-counter
// - mode 2: low byte counts, reloaded from high byte
// - timer 0 low byte readable, writable, resets to zero
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_consts.svh"

module dual_timer_counter #(
  parameter int INT_DIV = `INT_CLK_DIV
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic        ext_irq0_pin,
  input  wire logic        ext_irq1_pin,
  input  wire logic        t0_count_pin,
  input  wire logic        t1_count_pin,
  // cpu side
  input  wire logic        ext_irq0_vector_ack,
  output logic             irq
);
  import dual_timer_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // returns {overflow, high, low} after one count step
  function automatic logic [16:0] step(input timer_mode_t m,
                                       input logic [7:0] hi,
                                       input logic [7:0] lo);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    case (m)
      MODE_13BIT: begin
        if (lo[4:0] == 5'h1f) begin
          r[16:8] = {1'b0, hi} + 9'h001;
          r[7:0]  = {lo[7:5], 5'h00};
        end else begin
          r[7:0] = {lo[7:5], lo[4:0] + 5'h01};
        end
      end
      MODE_16BIT: r = {1'b0, hi, lo} + 17'h00001;
      MODE_RELOAD8: begin
        if (lo == 8'hff) r = {1'b1, hi, hi};
        else r[7:0] = lo + 8'h01;
      end
      default: r = {1'b0, hi, lo};
    endcase
    return r;
  endfunction

  function automatic logic hit(input logic [11:0] a,
                               input logic [9:0] idx);
    return a[11:2] == idx;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [3:0] pin_prev;
  logic       irq0_lvl;
  logic       irq1_lvl;
  logic       t0_fall;
  logic       t1_fall;
  logic       irq0_fall;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_meta <= 4'hf;
      pin_sync <= 4'hf;
      pin_prev <= 4'hf;
    end else begin
      pin_meta <= {t1_count_pin, t0_count_pin, ext_irq1_pin, ext_irq0_pin};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign irq0_lvl  = pin_sync[0];
  assign irq1_lvl  = pin_sync[1];
  assign irq0_fall = pin_prev[0] & ~pin_sync[0];
  assign t0_fall   = pin_prev[2] & ~pin_sync[2];
  assign t1_fall   = pin_prev[3] & ~pin_sync[3];

  // ---------------------------------------------------------------
  // internal clock divider
  // ---------------------------------------------------------------
  localparam int DW = $clog2(INT_DIV + 1);
  logic [DW-1:0] div_cnt;
  logic          int_tick;

  // with INT_DIV of 1 the tick is high on every clock
  assign int_tick = (div_cnt == DW'(INT_DIV - 1));

  always_ff @(posedge clk_sys) begin
    if (srst) div_cnt <= '0;
    else if (int_tick) div_cnt <= '0;
    else div_cnt <= div_cnt + DW'(1);
  end

  // ---------------------------------------------------------------
  // register access decode
  // ---------------------------------------------------------------
  logic       wr;
  logic       mapped;
  logic [7:0] wbyte;
  // one write strobe per register
  logic       wr_ctrl;
  logic       wr_mode;
  logic       wr_t0_low;
  logic       wr_t1_low;
  logic       wr_t0_high;
  logic       wr_t1_high;
  logic       wr_status;
  logic       wr_mask;

  assign wr    = psel & penable & pwrite;
  assign wbyte = pwdata[7:0];
  assign wr_ctrl    = wr & hit(paddr, `IDX_IRQ_CTRL);
  assign wr_mode    = wr & hit(paddr, `IDX_TIMER_MODE);
  assign wr_t0_low  = wr & hit(paddr, `IDX_T0_LOW);
  assign wr_t1_low  = wr & hit(paddr, `IDX_T1_LOW);
  assign wr_t0_high = wr & hit(paddr, `IDX_T0_HIGH);
  assign wr_t1_high = wr & hit(paddr, `IDX_T1_HIGH);
  assign wr_status  = wr & hit(paddr, `IDX_EVT_STATUS);
  assign wr_mask    = wr & hit(paddr, `IDX_EVT_MASK);
  assign mapped = hit(paddr, `IDX_IRQ_CTRL) | hit(paddr, `IDX_TIMER_MODE) |
                  hit(paddr, `IDX_T0_LOW) | hit(paddr, `IDX_T1_LOW) |
                  hit(paddr, `IDX_T0_HIGH) | hit(paddr, `IDX_T1_HIGH) |
                  hit(paddr, `IDX_EVT_STATUS) | hit(paddr, `IDX_EVT_MASK);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [7:0] timer_mode_control;
  logic       ext_irq0_type_sel;
  logic [1:0] timer_run_bit;
  logic [2:0] evt_mask;

  always_ff @(posedge clk_sys) begin
    if (srst) timer_mode_control <= `RST_BYTE;
    else if (wr_mode)
      timer_mode_control <= wbyte;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ext_irq0_type_sel <= 1'b0;
      timer_run_bit     <= 2'b00;
    end else if (wr_ctrl) begin
      ext_irq0_type_sel <= wbyte[`CTRL_TYPE_BIT];
      timer_run_bit     <= {wbyte[`CTRL_RUN1_BIT], wbyte[`CTRL_RUN0_BIT]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) evt_mask <= `RST_EVT;
    else if (wr_mask) evt_mask <= pwdata[2:0];
  end

  // ---------------------------------------------------------------
  // external interrupt 0 flag
  // ---------------------------------------------------------------
  logic ext_irq0_flag;
  logic irq0_set;

  // edge type: falling edge; level type: pin low
  assign irq0_set = ext_irq0_type_sel ? irq0_fall : ~irq0_lvl;

  always_ff @(posedge clk_sys) begin
    if (srst) ext_irq0_flag <= 1'b0;
    else if (!ext_irq0_type_sel) ext_irq0_flag <= ~irq0_lvl;
    else if (irq0_fall) ext_irq0_flag <= 1'b1;
    else if (ext_irq0_vector_ack) ext_irq0_flag <= 1'b0;
  end

  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  logic [7:0]  timer0_count_low;
  logic [7:0]  timer1_count_low;
  logic [7:0]  timer0_count_high;
  logic [7:0]  timer1_count_high;
  logic [1:0]  enable;
  logic [1:0]  adv;
  logic [16:0] next_t0;
  logic [16:0] next_t1;
  logic [3:0]  nib0;
  logic [3:0]  nib1;

  assign nib0 = timer_mode_control[3:0];
  assign nib1 = timer_mode_control[7:4];

  // gate bit is nibble bit 3, select bit is nibble bit 2
  assign enable[0] = timer_run_bit[0] & (~nib0[3] | irq0_lvl);
  assign enable[1] = timer_run_bit[1] & (~nib1[3] | irq1_lvl);
  assign adv[0] = enable[0] & (nib0[2] ? t0_fall : int_tick);
  assign adv[1] = enable[1] & (nib1[2] ? t1_fall : int_tick);

  assign next_t0 = step(timer_mode_t'(nib0[1:0]),
                        timer0_count_high, timer0_count_low);
  assign next_t1 = step(timer_mode_t'(nib1[1:0]),
                        timer1_count_high, timer1_count_low);

  // software writes take priority over a count in the same cycle
  always_ff @(posedge clk_sys) begin
    if (srst) timer0_count_low <= `RST_BYTE;
    else if (wr_t0_low) timer0_count_low <= wbyte;
    else if (adv[0]) timer0_count_low <= next_t0[7:0];
  end

  always_ff @(posedge clk_sys) begin
    if (srst) timer0_count_high <= `RST_BYTE;
    else if (wr_t0_high) timer0_count_high <= wbyte;
    else if (adv[0]) timer0_count_high <= next_t0[15:8];
  end

  always_ff @(posedge clk_sys) begin
    if (srst) timer1_count_low <= `RST_BYTE;
    else if (wr_t1_low) timer1_count_low <= wbyte;
    else if (adv[1]) timer1_count_low <= next_t1[7:0];
  end

  always_ff @(posedge clk_sys) begin
    if (srst) timer1_count_high <= `RST_BYTE;
    else if (wr_t1_high) timer1_count_high <= wbyte;
    else if (adv[1]) timer1_count_high <= next_t1[15:8];
  end

  // ---------------------------------------------------------------
  // event status and interrupt
  // ---------------------------------------------------------------
  logic [2:0] evt_status;
  logic [2:0] evt_set;
  logic [2:0] evt_clr;
  logic [1:0] ovf;

  // a wrap of the 13-, 16- or 8-bit count on an advancing cycle
  assign ovf     = {adv[1] & next_t1[16], adv[0] & next_t0[16]};
  assign evt_set = {ovf, irq0_set};
  assign evt_clr = wr_status ? pwdata[2:0] : 3'h0;

  // set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (srst) evt_status <= `RST_EVT;
    else evt_status <= (evt_status & ~evt_clr) | evt_set;
  end

  assign irq = |(evt_status & evt_mask);

  // ---------------------------------------------------------------
  // read data, captured in the setup cycle
  // ---------------------------------------------------------------
  logic [7:0] rbyte;

  always_comb begin
    rbyte = 8'h00;
    if (hit(paddr, `IDX_IRQ_CTRL)) begin
      rbyte[`CTRL_TYPE_BIT] = ext_irq0_type_sel;
      rbyte[`CTRL_FLAG_BIT] = ext_irq0_flag;
      rbyte[`CTRL_RUN0_BIT] = timer_run_bit[0];
      rbyte[`CTRL_RUN1_BIT] = timer_run_bit[1];
    end
    if (hit(paddr, `IDX_TIMER_MODE)) rbyte = timer_mode_control;
    if (hit(paddr, `IDX_T0_LOW)) rbyte = timer0_count_low;
    if (hit(paddr, `IDX_T1_LOW)) rbyte = timer1_count_low;
    if (hit(paddr, `IDX_T0_HIGH)) rbyte = timer0_count_high;
    if (hit(paddr, `IDX_T1_HIGH)) rbyte = timer1_count_high;
    if (hit(paddr, `IDX_EVT_STATUS)) rbyte = {5'h00, evt_status};
    if (hit(paddr, `IDX_EVT_MASK)) rbyte = {5'h00, evt_mask};
  end

  always_ff @(posedge clk_sys) begin
    if (srst) prdata <= 32'h0000_0000;
    else if (psel && !penable) prdata <= {24'h00_0000, rbyte};
  end

endmodule

`default_nettype wire

// >>> tb/timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module timer_checker (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        srst,
  // apb slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // cpu side
  input wire logic        irq
);
  logic [9:0] idx;
  logic       hit;
  logic       acc;
  assign idx = paddr[11:2];
  assign hit = (idx >= 10'h088 && idx <= 10'h08d) || idx == 10'h090
               || idx == 10'h091;
  assign acc = psel && penable;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ----
  // assertions
  // ----
  a_pready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (acc && !hit |-> pslverr)
    else $error("no error on unmapped");
  a_err_mapped: assert property (acc && hit |-> !pslverr)
    else $error("error on mapped");
  a_err_setup: assert property (psel && !penable |-> !pslverr)
    else $error("error in setup");
  a_unmapped_zero: assert property (psel && !penable && !hit |=> !prdata)
    else $error("unmapped read not zero");
  a_byte_only: assert property (prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved");
  a_irq_reset: assert property ($past(srst) |-> !irq)
    else $error("irq after reset");
  a_mask_off: assert property (acc && pwrite && idx == 10'h091
    && pwdata[2:0] == 3'h0 |=> !irq) else $error("masked irq high");
  cover property (acc && !hit);
  cover property ($fell(irq));
  cover property (acc && pwrite && idx == 10'h089);
endmodule
bind dual_timer_counter timer_checker timer_checker_inst (.clk_sys, .srst,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .irq);
`default_nettype wire

// >>> tb/pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  // clock
  input  wire logic clk_sys,
  // pins, idle high
  output logic      ext_irq0_pin,
  output logic      ext_irq1_pin,
  output logic      t0_count_pin,
  output logic      t1_count_pin
);
  initial begin
    ext_irq0_pin = 1'b1;
    ext_irq1_pin = 1'b1;
    t0_count_pin = 1'b1;
    t1_count_pin = 1'b1;
  end
  task automatic set_pin(input int s, input logic v);
    case (s)
      0: ext_irq0_pin <= v;
      1: ext_irq1_pin <= v;
      2: t0_count_pin <= v;
      default: t1_count_pin <= v;
    endcase
  endtask
  // falls spaced 3 low, 4 high so the synchroniser sees each one
  task automatic pulse(input int s, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      set_pin(s, 1'b0);
      repeat (3) @(posedge clk_sys);
      set_pin(s, 1'b1);
      repeat (3) @(posedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_sys, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        ext_irq0_pin, ext_irq1_pin, t0_count_pin, t1_count_pin;
  logic        ack, irq;
  int          error_cnt, total_checks;
  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;
  dual_timer_counter #(.INT_DIV(1)) dual_timer_counter_inst (.clk_sys,
    .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ext_irq0_pin, .ext_irq1_pin, .t0_count_pin, .t1_count_pin,
    .ext_irq0_vector_ack(ack), .irq);
  pin_model pin_model_inst (.clk_sys, .ext_irq0_pin, .ext_irq1_pin,
    .t0_count_pin, .t1_count_pin);
  // ----
  // tasks
  // ----
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    if (pready !== 1'b1) begin
      error_cnt++;
      print_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdc(input logic [9:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    check(rd, {24'h0, e});
  endtask
  task automatic irq_is(input logic e);
    @(negedge clk_sys);
    check({31'h0, irq}, {31'h0, e});
    @(posedge clk_sys);
  endtask
  // t selects timer 0 or timer 1 (its bytes, run bit and count pin)
  task automatic cnt_run(input int t, input logic [7:0] m, h, l,
                         input int n, input logic [7:0] eh, el);
    apb(1'b1, 10'h08c + 10'(t), h);
    apb(1'b1, 10'h08a + 10'(t), l);
    apb(1'b1, 10'h089, m);
    apb(1'b1, 10'h088, (t == 0) ? 8'h10 : 8'h40);
    pin_model_inst.pulse(2 + t, n);
    repeat (4) @(posedge clk_sys);
    apb(1'b1, 10'h088, 8'h00);
    rdc(10'h08a + 10'(t), el);
    rdc(10'h08c + 10'(t), eh);
  endtask
  task automatic tmr_run(input logic [7:0] m);
    apb(1'b1, 10'h08a, 8'h00);
    apb(1'b1, 10'h08c, 8'h00);
    apb(1'b1, 10'h089, m);
    apb(1'b1, 10'h088, 8'h10);
    repeat (10) @(posedge clk_sys);
    apb(1'b1, 10'h088, 8'h00);
    apb(1'b0, 10'h08a, 8'h00);
  endtask
  // ----
  // sequence
  // ----
  initial begin
    srst = 1'b1;
    {psel, penable, pwrite, ack} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    error_cnt = 0;
    total_checks = 0;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rdc(10'h089, 8'h00);
    rdc(10'h08a, 8'h00);
    rdc(10'h0ff, 8'h00);
    apb(1'b1, 10'h08a, 8'ha5);
    rdc(10'h08a, 8'ha5);
    $display("end registers");
    pin_model_inst.set_pin(0, 1'b0);
    tmr_run(8'h09);
    check(rd, 32'h0);
    tmr_run(8'h01);
    check({31'h0, rd[7:0] > 8'd8 && rd[7:0] < 8'd16}, 32'h1);
    pin_model_inst.set_pin(0, 1'b1);
    repeat (4) @(posedge clk_sys);
    tmr_run(8'h09);
    check({31'h0, rd[7:0] > 8'd8 && rd[7:0] < 8'd16}, 32'h1);
    apb(1'b1, 10'h090, 8'h07);
    $display("end gating");
    cnt_run(0, 8'h05, 8'h00, 8'hfe, 3, 8'h01, 8'h01);
    cnt_run(0, 8'h06, 8'hfe, 8'hfe, 3, 8'hfe, 8'hff);
    cnt_run(0, 8'h04, 8'h00, 8'h1e, 3, 8'h01, 8'h01);
    cnt_run(0, 8'h07, 8'h00, 8'h10, 2, 8'h00, 8'h10);
    rdc(10'h08b, 8'h00);
    rdc(10'h090, 8'h02);
    apb(1'b1, 10'h090, 8'h07);
    cnt_run(1, 8'h50, 8'hff, 8'hfe, 3, 8'h00, 8'h01);
    rdc(10'h090, 8'h04);
    pin_model_inst.set_pin(1, 1'b0);
    cnt_run(1, 8'hd0, 8'h00, 8'h20, 3, 8'h00, 8'h20);
    pin_model_inst.set_pin(1, 1'b1);
    cnt_run(1, 8'hd0, 8'h00, 8'h20, 3, 8'h00, 8'h23);
    apb(1'b1, 10'h090, 8'h07);
    $display("end modes");
    apb(1'b1, 10'h091, 8'h01);
    apb(1'b1, 10'h088, 8'h01);
    irq_is(1'b0);
    pin_model_inst.pulse(0, 1);
    rdc(10'h088, 8'h03);
    irq_is(1'b1);
    ack <= 1'b1;
    @(posedge clk_sys);
    ack <= 1'b0;
    @(posedge clk_sys);
    rdc(10'h088, 8'h01);
    apb(1'b1, 10'h090, 8'h07);
    irq_is(1'b0);
    apb(1'b1, 10'h088, 8'h00);
    pin_model_inst.set_pin(0, 1'b0);
    repeat (4) @(posedge clk_sys);
    rdc(10'h088, 8'h02);
    pin_model_inst.set_pin(0, 1'b1);
    repeat (4) @(posedge clk_sys);
    rdc(10'h088, 8'h00);
    apb(1'b1, 10'h091, 8'h00);
    $display("end interrupt");
    print_verdict();
  end
endmodule
`default_nettype wire
